// ==== src/mcd_pkg.sv ====
// constants shared by the manchester codec
package mcd_pkg;

  // ----------------------------------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 12;
  localparam int PIN_RX_CLOCK = 0;
  localparam int PIN_RX_POS = 1;
  localparam int PIN_RX_NEG = 2;
  localparam int PIN_RX_UNI = 3;
  localparam int PIN_DEC_RST = 4;
  localparam int PIN_MCLR = 5;
  localparam int PIN_ENC_CLK = 6;
  localparam int PIN_INHIBIT = 7;
  localparam int PIN_TX_DATA = 8;
  localparam int PIN_TX_EN = 9;
  localparam int PIN_SYNC_SEL = 10;
  localparam int PIN_SEND_CLK = 11;

  // ----------------------------------------------------------------
  // decoder timing, in rx_clock samples; word positions in bit cells
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_OVERSAMPLE = 4'hc;
  localparam logic [3:0] RX_PHASE_LAST = 4'hb;
  localparam logic [3:0] RX_HALF = 4'h6;
  localparam logic [3:0] RX_SAMPLE_A = 4'h3;
  localparam logic [3:0] RX_SAMPLE_B = 4'h9;
  localparam logic [4:0] SYNC_RUN_MIN = 5'h11;
  localparam logic [4:0] SYNC_RUN_MAX = 5'h13;
  localparam logic [4:0] RUN_SAT = 5'h1f;
  localparam logic [4:0] RX_LAST_BIT = 5'h10;
  localparam logic [4:0] RX_OUT_LAG = 5'h02;
  localparam logic [4:0] RX_OUT_END = 5'h11;

  // ----------------------------------------------------------------
  // encoder timing in tx_shift_clock periods, divider count in enc_clk_in ticks
  // ----------------------------------------------------------------
  localparam logic [4:0] ENC_LAST_PERIOD = 5'h13;
  localparam logic [4:0] ENC_SYNC_SWAP = 5'h02;
  localparam logic [4:0] ENC_DATA_FIRST = 5'h03;
  localparam logic [4:0] ENC_SD_FIRST = 5'h02;
  localparam logic [4:0] ENC_SD_LAST = 5'h11;
  localparam logic [1:0] DIV_SIX_HALF = 2'h2;

  typedef enum logic [1:0] {
    MCD_HUNT = 2'b00,
    MCD_SYNC_B = 2'b01,
    MCD_BITS = 2'b10
  } mcd_rx_state_type;

endpackage

// ==== src/mcd_codec.sv ====
// manchester ii encoder and decoder, one clock, pins oversampled
`timescale 1ns/1ps

module mcd_codec import mcd_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_clear,
  input wire logic rx_clock,
  input wire logic rx_pos_in,
  input wire logic rx_neg_in,
  input wire logic rx_unipolar_in,
  input wire logic decoder_reset,
  output logic rx_valid_word,
  output logic take_data,
  output logic rx_serial_out,
  output logic rx_shift_clock,
  output logic rx_cmd_sync_flag,
  input wire logic enc_clk_in,
  input wire logic tx_send_clock,
  input wire logic tx_output_inhibit,
  input wire logic tx_serial_in,
  input wire logic tx_enable,
  input wire logic sync_select,
  output logic tx_shift_clock,
  output logic send_data,
  output logic tx_pos_out,
  output logic tx_neg_out,
  output logic div_six_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] pin_s1_r;
  logic [PIN_COUNT-1:0] pin_s2_r;
  logic [PIN_COUNT-1:0] pin_s3_r;

  assign pins = {tx_send_clock, sync_select, tx_enable, tx_serial_in, tx_output_inhibit,
                 enc_clk_in, master_clear, decoder_reset, rx_unipolar_in, rx_neg_in,
                 rx_pos_in, rx_clock};

  // s3 is only an edge-detect delay on the already synchronised s2
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic clear;
  logic rx_tick;
  logic tx_tick;
  logic ec_tick;
  logic line;
  logic bus_idle;

  assign clear = !reset_n || pin_s2_r[PIN_MCLR];
  assign rx_tick = pin_s2_r[PIN_RX_CLOCK] && !pin_s3_r[PIN_RX_CLOCK];
  assign tx_tick = pin_s2_r[PIN_SEND_CLK] && !pin_s3_r[PIN_SEND_CLK];
  assign ec_tick = pin_s2_r[PIN_ENC_CLK] && !pin_s3_r[PIN_ENC_CLK];
  // unused path sits low (pos low / unipolar low), so an or serves both inputs
  assign line = pin_s2_r[PIN_RX_UNI] || (pin_s2_r[PIN_RX_POS] && !pin_s2_r[PIN_RX_NEG]);
  // an undriven pair reads low like the negative state; a data sync opens
  // at that level, so idle samples must not count towards its run
  assign bus_idle = !pin_s2_r[PIN_RX_POS] && !pin_s2_r[PIN_RX_NEG];

  // ----------------------------------------------------------------
  // decoder
  // ----------------------------------------------------------------
  mcd_rx_state_type rx_state_r;
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;
  logic [4:0] run_r;
  logic last_r;
  logic first_half_r;
  logic cmd_r;
  logic err_r;
  logic [4:0] bit_idx_r;
  logic [16:0] bits_r;
  logic rx_valid_word_r;
  logic take_data_r;
  logic rx_serial_out_r;
  logic rx_shift_clock_r;
  logic rx_cmd_sync_flag_r;
  logic [4:0] out_idx;
  logic cell_bad;

  always_comb begin
    phase_nxt = (phase_r == RX_PHASE_LAST) ? 4'h0 : phase_r + 4'h1;
    out_idx = bit_idx_r - RX_OUT_LAG;
    cell_bad = (line == first_half_r);
  end

  // the bit phase free-runs while hunting so the shift clock never stops
  always_ff @(posedge clk) begin
    if (clear) begin
      phase_r <= '0;
      rx_shift_clock_r <= 1'b0;
      run_r <= '0;
      last_r <= 1'b0;
    end else if (rx_tick) begin
      phase_r <= (rx_state_r == MCD_SYNC_B && run_r == SYNC_RUN_MIN && line == last_r) ?
                 RX_PHASE_LAST : phase_nxt;
      rx_shift_clock_r <= (phase_nxt >= RX_HALF);
      last_r <= line;
      if (bus_idle) begin
        run_r <= '0;
      end else if (line != last_r) begin
        run_r <= 5'h01;
      end else if (run_r != RUN_SAT) begin
        run_r <= run_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      rx_state_r <= MCD_HUNT;
      first_half_r <= 1'b0;
      cmd_r <= 1'b0;
      err_r <= 1'b0;
      bit_idx_r <= '0;
      bits_r <= '0;
      rx_valid_word_r <= 1'b0;
      take_data_r <= 1'b0;
      rx_serial_out_r <= 1'b0;
      rx_cmd_sync_flag_r <= 1'b0;
    end else if (rx_tick) begin
      if (pin_s2_r[PIN_DEC_RST] && phase_nxt == RX_HALF) begin
        rx_state_r <= MCD_HUNT;
        take_data_r <= 1'b0;
        rx_cmd_sync_flag_r <= 1'b0;
      end else begin
        case (rx_state_r)
          MCD_HUNT: begin
            // sync is 1.5 bit times at one level then 1.5 at the other
            if (!bus_idle && line != last_r && run_r >= SYNC_RUN_MIN &&
                run_r <= SYNC_RUN_MAX) begin
              rx_state_r <= MCD_SYNC_B;
              cmd_r <= last_r;
            end
          end
          MCD_SYNC_B: begin
            if (line != last_r) begin
              rx_state_r <= MCD_HUNT;
            end else if (run_r == SYNC_RUN_MIN) begin
              rx_state_r <= MCD_BITS;
              bit_idx_r <= '0;
              err_r <= 1'b0;
            end
          end
          MCD_BITS: begin
            if (phase_nxt == RX_SAMPLE_A) begin
              first_half_r <= line;
            end
            if (phase_nxt == RX_SAMPLE_B && bit_idx_r <= RX_LAST_BIT) begin
              bits_r[bit_idx_r] <= first_half_r;
              err_r <= err_r || cell_bad;
              if (bit_idx_r == 5'h01 && (err_r || cell_bad)) begin
                rx_state_r <= MCD_HUNT;
              end
            end
            if (phase_nxt == 4'h0 && bit_idx_r >= RX_OUT_LAG) begin
              take_data_r <= 1'b1;
              rx_cmd_sync_flag_r <= cmd_r;
              rx_serial_out_r <= bits_r[out_idx[3:0]];
              if (bit_idx_r == RX_OUT_LAG) begin
                rx_valid_word_r <= 1'b0;
              end
            end
            if (phase_nxt == RX_PHASE_LAST) begin
              bit_idx_r <= bit_idx_r + 5'h01;
              if (bit_idx_r == RX_OUT_END) begin
                rx_state_r <= MCD_HUNT;
                take_data_r <= 1'b0;
                rx_cmd_sync_flag_r <= 1'b0;
                rx_valid_word_r <= !err_r && (^bits_r);
              end
            end
          end
          default: rx_state_r <= MCD_HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // encoder
  // ----------------------------------------------------------------
  logic half_r;
  logic enc_active_r;
  logic [4:0] per_r;
  logic [4:0] per_nxt;
  logic enc_cmd_r;
  logic data_bit_r;
  logic ones_r;
  logic tx_line_r;
  logic tx_drive_r;
  logic tx_shift_clock_r;
  logic send_data_r;
  logic tx_pos_out_r;
  logic tx_neg_out_r;
  logic continuing;
  logic starting;

  // first half-cell level of period q; the second half inverts it except in sync periods 0 and 2
  function automatic logic first_level(input logic [4:0] q, input logic cmd,
                                       input logic dbit, input logic ones);
    logic lvl;
    lvl = cmd;
    if (q == ENC_SYNC_SWAP) begin
      lvl = !cmd;
    end else if (q == ENC_LAST_PERIOD) begin
      lvl = !ones;
    end else if (q >= ENC_DATA_FIRST) begin
      lvl = dbit;
    end
    return lvl;
  endfunction

  always_comb begin
    continuing = enc_active_r && per_r != ENC_LAST_PERIOD;
    starting = !continuing && pin_s2_r[PIN_TX_EN];
    per_nxt = continuing ? per_r + 5'h01 : 5'h00;
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      half_r <= 1'b0;
      tx_shift_clock_r <= 1'b0;
      enc_active_r <= 1'b0;
      per_r <= '0;
      enc_cmd_r <= 1'b0;
      data_bit_r <= 1'b0;
      ones_r <= 1'b0;
      tx_line_r <= 1'b0;
      tx_drive_r <= 1'b0;
      send_data_r <= 1'b0;
    end else if (tx_tick) begin
      half_r <= !half_r;
      tx_shift_clock_r <= !half_r;
      if (half_r) begin
        // falling shift clock edge opens a new period
        enc_active_r <= continuing || starting;
        tx_drive_r <= continuing || starting;
        per_r <= per_nxt;
        send_data_r <= (continuing || starting) && per_nxt >= ENC_SD_FIRST &&
                       per_nxt <= ENC_SD_LAST;
        if (starting) begin
          enc_cmd_r <= pin_s2_r[PIN_SYNC_SEL];
          ones_r <= 1'b0;
          tx_line_r <= pin_s2_r[PIN_SYNC_SEL];
        end else begin
          tx_line_r <= first_level(per_nxt, enc_cmd_r, data_bit_r, ones_r);
        end
      end else begin
        if (send_data_r) begin
          data_bit_r <= pin_s2_r[PIN_TX_DATA];
          ones_r <= ones_r ^ pin_s2_r[PIN_TX_DATA];
        end
        if (per_r == 5'h00) begin
          tx_line_r <= enc_cmd_r;
        end else if (per_r < ENC_DATA_FIRST) begin
          tx_line_r <= !enc_cmd_r;
        end else begin
          tx_line_r <= !tx_line_r;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_pos_out_r <= 1'b1;
      tx_neg_out_r <= 1'b1;
    end else begin
      tx_pos_out_r <= !(tx_drive_r && tx_line_r && pin_s2_r[PIN_INHIBIT]);
      tx_neg_out_r <= !(tx_drive_r && !tx_line_r && pin_s2_r[PIN_INHIBIT]);
    end
  end

  // ----------------------------------------------------------------
  // divide-by-six on enc_clk_in
  // ----------------------------------------------------------------
  logic [1:0] div_cnt_r;
  logic div_six_out_r;

  always_ff @(posedge clk) begin
    if (clear) begin
      div_cnt_r <= '0;
      div_six_out_r <= 1'b0;
    end else if (ec_tick) begin
      if (div_cnt_r == DIV_SIX_HALF) begin
        div_cnt_r <= '0;
        div_six_out_r <= !div_six_out_r;
      end else begin
        div_cnt_r <= div_cnt_r + 2'h1;
      end
    end
  end

  assign rx_valid_word = rx_valid_word_r;
  assign take_data = take_data_r;
  assign rx_serial_out = rx_serial_out_r;
  assign rx_shift_clock = rx_shift_clock_r;
  assign rx_cmd_sync_flag = rx_cmd_sync_flag_r;
  assign tx_shift_clock = tx_shift_clock_r;
  assign send_data = send_data_r;
  assign tx_pos_out = tx_pos_out_r;
  assign tx_neg_out = tx_neg_out_r;
  assign div_six_out = div_six_out_r;

endmodule // mcd_codec

// ==== tb/mcd_codec_monitor.sv ====
// concurrent checks on the manchester codec ports
`timescale 1ns/1ps
module mcd_codec_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_clear,
  input wire logic tx_output_inhibit,
  input wire logic decoder_reset,
  input wire logic rx_valid_word,
  input wire logic take_data,
  input wire logic rx_serial_out,
  input wire logic rx_shift_clock,
  input wire logic rx_cmd_sync_flag,
  input wire logic tx_shift_clock,
  input wire logic send_data,
  input wire logic tx_pos_out,
  input wire logic tx_neg_out,
  input wire logic div_six_out
);
  logic [3:0] mc_r;
  logic clr;
  // the clear pin is synchronised, so its effect outlasts the pin itself
  always_ff @(posedge clk) mc_r <= {mc_r[2:0], master_clear};
  assign clr = master_clear || (mc_r != 4'h0);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_inhibit_idle_high: assert property (!tx_output_inhibit [*5] |-> tx_pos_out && tx_neg_out)
    else $error("tx outputs driven while inhibited");
  a_never_both_low: assert property (tx_pos_out || tx_neg_out)
    else $error("both tx outputs active");
  a_flag_needs_take: assert property (rx_cmd_sync_flag |-> take_data)
    else $error("command flag outside take_data");
  a_valid_at_end: assert property ($rose(rx_valid_word) |->
    !take_data && ($past(take_data) || $past(take_data, 2)))
    else $error("valid word not at end of word");
  a_take_min_run: assert property (disable iff (!reset_n || clr)
    $rose(take_data) |-> take_data [*8])
    else $error("take_data pulse too short");
  a_serial_low_phase: assert property (take_data && $changed(rx_serial_out) |-> !rx_shift_clock)
    else $error("serial out moved while shift clock high");
  a_sd_on_fall: assert property ($rose(send_data) |-> !tx_shift_clock)
    else $error("send_data rose with shift clock high");
  a_sd_min_run: assert property (disable iff (!reset_n || clr)
    $rose(send_data) |-> send_data [*8])
    else $error("send_data pulse too short");
  a_div_steady: assert property (disable iff (!reset_n || clr)
    $changed(div_six_out) |=> $stable(div_six_out) [*8])
    else $error("divider output toggles too fast");
  c_cmd_word: cover property ($rose(rx_cmd_sync_flag));
  c_valid: cover property ($rose(rx_valid_word));
  c_abort: cover property (decoder_reset && $fell(take_data));
endmodule // mcd_codec_monitor

bind mcd_codec mcd_codec_monitor mcd_codec_monitor_inst (.clk(clk), .reset_n(reset_n),
  .master_clear(master_clear), .tx_output_inhibit(tx_output_inhibit),
  .decoder_reset(decoder_reset), .rx_valid_word(rx_valid_word), .take_data(take_data),
  .rx_serial_out(rx_serial_out), .rx_shift_clock(rx_shift_clock),
  .rx_cmd_sync_flag(rx_cmd_sync_flag), .tx_shift_clock(tx_shift_clock),
  .send_data(send_data), .tx_pos_out(tx_pos_out), .tx_neg_out(tx_neg_out),
  .div_six_out(div_six_out));

// ==== tb/mcd_line_model.sv ====
// bus comparator, serial data source and receive shift register
`timescale 1ns/1ps
module mcd_line_model (
  input wire logic clk,
  input wire logic tx_pos_out,
  input wire logic tx_neg_out,
  input wire logic send_data,
  input wire logic tx_shift_clock,
  input wire logic take_data,
  input wire logic rx_serial_out,
  input wire logic rx_shift_clock,
  input wire logic [15:0] src_word,
  input wire logic uni_mode,
  output logic rx_pos_in,
  output logic rx_neg_in,
  output logic rx_unipolar_in,
  output logic tx_serial_in,
  output logic [15:0] word_out
);
  logic tsc_q, rsc_q;
  logic [4:0] idx;
  initial begin
    tx_serial_in = 1'b0;
    word_out = 16'h0000;
  end
  // an undriven bus reads as neither state; unipolar mode feeds the
  // negative-sense output in directly and parks the pair at its fixed levels
  assign rx_pos_in = !uni_mode && !tx_pos_out;
  assign rx_neg_in = uni_mode || !tx_neg_out;
  assign rx_unipolar_in = uni_mode && tx_neg_out;
  always @(posedge clk) begin
    tsc_q <= tx_shift_clock;
    rsc_q <= rx_shift_clock;
    if (!send_data) begin
      idx <= 5'h0f;
      // released source toggles so no stale bit can pass for data
      tx_serial_in <= ~tx_serial_in;
    end else begin
      tx_serial_in <= src_word[idx[3:0]];
      if (tx_shift_clock && !tsc_q) idx <= idx - 5'h01;
    end
    if (take_data && rx_shift_clock && !rsc_q) word_out <= {word_out[14:0], rx_serial_out};
  end
endmodule // mcd_line_model

// ==== tb/testbench.sv ====
// loopback testbench for the manchester codec
`timescale 1ns/1ps
module testbench;
  import mcd_pkg::*;
  logic clk, reset_n, master_clear, rx_clock, rx_pos_in, rx_neg_in, rx_unipolar_in;
  logic decoder_reset, rx_valid_word, take_data, rx_serial_out, rx_shift_clock;
  logic rx_cmd_sync_flag, enc_clk_in, tx_send_clock, tx_output_inhibit, tx_serial_in;
  logic tx_enable, sync_select, tx_shift_clock, send_data, tx_pos_out, tx_neg_out, div_six_out;
  logic [15:0] src_word, word_out;
  logic uni_mode;
  int cnt, cycles, miscompares, n_checks;
  mcd_codec mcd_codec_inst (.clk(clk), .reset_n(reset_n), .master_clear(master_clear),
    .rx_clock(rx_clock), .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in),
    .rx_unipolar_in(rx_unipolar_in), .decoder_reset(decoder_reset),
    .rx_valid_word(rx_valid_word), .take_data(take_data), .rx_serial_out(rx_serial_out),
    .rx_shift_clock(rx_shift_clock), .rx_cmd_sync_flag(rx_cmd_sync_flag),
    .enc_clk_in(enc_clk_in), .tx_send_clock(tx_send_clock),
    .tx_output_inhibit(tx_output_inhibit), .tx_serial_in(tx_serial_in),
    .tx_enable(tx_enable), .sync_select(sync_select), .tx_shift_clock(tx_shift_clock),
    .send_data(send_data), .tx_pos_out(tx_pos_out), .tx_neg_out(tx_neg_out),
    .div_six_out(div_six_out));
  mcd_line_model mcd_line_model_inst (.clk(clk), .tx_pos_out(tx_pos_out),
    .tx_neg_out(tx_neg_out), .send_data(send_data), .tx_shift_clock(tx_shift_clock),
    .take_data(take_data), .rx_serial_out(rx_serial_out), .rx_shift_clock(rx_shift_clock),
    .src_word(src_word), .uni_mode(uni_mode), .rx_pos_in(rx_pos_in),
    .rx_neg_in(rx_neg_in), .rx_unipolar_in(rx_unipolar_in),
    .tx_serial_in(tx_serial_in), .word_out(word_out));
  always #2 clk = ~clk;
  // one 120-cycle frame: rx at 12x, send clock at 2x the bit rate
  always @(posedge clk) begin
    cnt <= (cnt == 119) ? 0 : cnt + 1;
    rx_clock <= (cnt % 10) < 5;
    tx_send_clock <= (cnt % 60) < 30;
    enc_clk_in <= (cnt % 8) < 4;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic send_word(input logic sel, input logic [15:0] w, input logic inh);
    int sd_n;
    logic took, flag;
    took = 1'b0;
    flag = 1'b0;
    @(posedge clk);
    src_word <= w;
    sync_select <= sel;
    tx_enable <= 1'b1;
    tx_output_inhibit <= !inh;
    do @(negedge clk); while (!send_data);
    sd_n = 1;
    @(posedge clk) tx_enable <= 1'b0;
    for (int i = 0; i < 4000 && !(took && !take_data); i++) begin
      @(negedge clk);
      sd_n += send_data;
      if (take_data && !took) flag = rx_cmd_sync_flag;
      took |= take_data;
    end
    @(negedge clk);
    check(16'(sd_n), 16'd1920);
    if (inh) begin
      check(took, 1'b0);
    end else begin
      check(flag, sel);
      check(word_out, w);
      check(rx_valid_word, 1'b1);
    end
    @(posedge clk) tx_output_inhibit <= 1'b1;
  endtask
  task automatic uni_word();
    @(posedge clk) uni_mode <= 1'b1;
    repeat (200) @(posedge clk);
    send_word(1'b0, 16'h1234, 1'b0);
    @(posedge clk) uni_mode <= 1'b0;
    repeat (200) @(posedge clk);
  endtask
  task automatic abort_word();
    @(posedge clk) tx_enable <= 1'b1;
    do @(negedge clk); while (!take_data);
    @(posedge clk) tx_enable <= 1'b0;
    decoder_reset <= 1'b1;
    repeat (200) @(negedge clk);
    check(take_data, 1'b0);
    check(rx_valid_word, 1'b0);
    @(posedge clk) decoder_reset <= 1'b0;
    repeat (2000) @(posedge clk);
  endtask
  task automatic clear_mid_word();
    @(posedge clk) tx_enable <= 1'b1;
    do @(negedge clk); while (!send_data);
    @(posedge clk) tx_enable <= 1'b0;
    master_clear <= 1'b1;
    repeat (8) @(posedge clk);
    master_clear <= 1'b0;
    @(negedge clk);
    check(send_data, 1'b0);
    check({tx_pos_out, tx_neg_out}, 2'b11);
    repeat (3000) @(posedge clk);
  endtask
  task automatic div_six();
    int n;
    n = 0;
    do @(negedge clk); while (div_six_out);
    do @(negedge clk); while (!div_six_out);
    while (div_six_out) begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'd24);
  endtask
  initial begin
    clk = 1'b0; reset_n = 1'b0; master_clear = 1'b0; rx_clock = 1'b0;
    uni_mode = 1'b0;
    decoder_reset = 1'b0; enc_clk_in = 1'b0; tx_send_clock = 1'b0;
    tx_output_inhibit = 1'b1; tx_enable = 1'b0; sync_select = 1'b0; src_word = 16'h0000;
    cnt = 0; cycles = 0; miscompares = 0; n_checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    send_word(1'b1, 16'ha5c3, 1'b0);
    send_word(1'b0, 16'h3c0f, 1'b0);
    uni_word();
    send_word(1'b1, 16'hffff, 1'b1);
    abort_word();
    clear_mid_word();
    div_six();
    print_verdict();
  end
endmodule // testbench
